//--- logic/debug_pin_mode_select.sv
// Behaviour
// - Pin is mode select during qualifying reset
// - Pin becomes debug line after any reset
// - High pin at qualifying reset end selects normal
// - Every bit lasts exactly 16 debug clocks
// - Bit timing runs at full bus clock
// - Release high with brief active speedup pulse
// - Internal pullup keeps open pin high
`timescale 1ns/1ps
module debug_pin_mode_select (
    input  wire logic                   i_core_clk,
    input  wire logic                   i_rst_n,
    input  wire logic                   i_qual_rst,
    input  wire logic                   i_pin_in,
    input  wire dbg_pin_pkg::tx_bit_t   i_tx_bit,
    output logic                        o_pin_out,
    output logic                        o_pin_oe,
    output logic                        o_pin_pullup_en,
    output logic                        o_tx_ready,
    output dbg_pin_pkg::rx_bit_t        o_rx_bit,
    output logic                        o_bkg_mode,
    output logic                        o_link_active
);
    import dbg_pin_pkg::*;

    pin_state_t  state_q;              // Pin role and link phase
    pin_state_t  state_d;
    logic        qual_seen_q;          // Current reset samples the mode
    logic [3:0]  bit_cnt_q;            // Phase inside the bit time
    logic        tx_active_q;          // Bit time started by us
    logic        tx_data_q;            // Bit value being sent
    logic        mode_q;               // Latched mode, 1 = background
    logic        pin_out_q;
    logic        pin_oe_q;
    logic        rx_valid_q;
    logic        rx_data_q;
    logic        pin_prev_q;           // Previous pin level, edge detect
    logic        tx_ready_q;           // Idle, a new bit may be handed in
    logic        link_q;               // Pin now serves as the debug line

    // Named decode terms
    wire         bit_last   = (bit_cnt_q == BIT_CNT_LAST);
    wire         host_start = pin_prev_q && !i_pin_in;
    wire         tx_start   = i_tx_bit.valid && (state_q == ST_IDLE);
    // A zero holds the line low until the end phase, a one only briefly
    wire [3:0]   low_len    = tx_data_q ? 4'h0 : LOW_END_PHASE;
    wire         drive_low  = tx_active_q && (bit_cnt_q <= low_len);
    // Speedup: one short driven high right after the driven low ends, before letting go
    wire         drive_hi   = tx_active_q && (bit_cnt_q > low_len)
                              && (bit_cnt_q <= low_len + SPEEDUP_LEN);
    wire         take_smp   = (state_q == ST_BIT) && !tx_active_q
                              && (bit_cnt_q == SAMPLE_PHASE);

    // Role select; reset always returns to mode-select
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_MODESEL: state_d = ST_IDLE;
            ST_IDLE: begin
                if (tx_start || host_start) begin
                    state_d = ST_BIT;
                end
            end
            ST_BIT: begin
                if (bit_last) begin
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_MODESEL;
        endcase
    end

    // State, bit counter and transmit capture
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            state_q     <= ST_MODESEL;
            bit_cnt_q   <= 4'h0;
            tx_active_q <= 1'b0;
            tx_data_q   <= 1'b0;
            pin_prev_q  <= 1'b1;
        end else begin
            state_q    <= state_d;
            pin_prev_q <= i_pin_in;
            // Full-rate counter, no prescaler, so bus clock speed works
            if (state_q == ST_BIT) begin
                bit_cnt_q <= bit_cnt_q + 4'h1;
            end else begin
                bit_cnt_q <= 4'h0;
            end
            if (tx_start) begin
                tx_active_q <= 1'b1;
                tx_data_q   <= i_tx_bit.data;
            end else if (state_q == ST_BIT && bit_last) begin
                tx_active_q <= 1'b0;
            end
        end
    end

    // Qualifying reset marker; only POR or force reset sample mode
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            qual_seen_q <= i_qual_rst ? 1'b1 : 1'b0;
        end else if (state_q == ST_MODESEL) begin
            qual_seen_q <= 1'b0;
        end
    end

    // Mode latch at the first edge after reset release
    always_ff @(posedge i_core_clk) begin
        if (state_q == ST_MODESEL && i_rst_n && qual_seen_q) begin
            mode_q <= i_pin_in ? ~MODE_BKG : MODE_BKG;
        end else if (!i_rst_n && i_qual_rst) begin
            mode_q <= MODE_RST_VAL;
        end
    end

    // Pin drive: never driven while in mode-select role
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            pin_out_q <= 1'b1;
            pin_oe_q  <= 1'b0;
        end else begin
            pin_out_q <= !drive_low;
            // Left undriven on the take edge: driving high there would
            // be a stray active high ahead of the falling edge
            pin_oe_q  <= (state_d == ST_BIT) && (drive_low || drive_hi);
        end
    end

    // Status flags taken from the next state, so the outputs come
    // straight from flops and still track the state register exactly
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            tx_ready_q <= 1'b0;
            link_q     <= 1'b0;
        end else begin
            tx_ready_q <= (state_d == ST_IDLE);
            link_q     <= (state_d != ST_MODESEL);
        end
    end

    // Receive sampling of host-started bit times
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            rx_valid_q <= 1'b0;
            rx_data_q  <= 1'b0;
        end else begin
            rx_valid_q <= take_smp;
            if (take_smp) begin
                rx_data_q <= i_pin_in;
            end
        end
    end

    assign o_pin_out       = pin_out_q;
    assign o_pin_oe        = pin_oe_q;
    // Pullup is static so a floating pin reads high
    assign o_pin_pullup_en = 1'b1;
    assign o_tx_ready      = tx_ready_q;
    assign o_rx_bit        = '{valid: rx_valid_q, data: rx_data_q};
    assign o_bkg_mode      = mode_q;
    assign o_link_active   = link_q;

    // Assertions; the reset-phase checks carry no disable, so they
    // still watch the pin while it serves as the mode select
    chk_bit_len: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        $rose(state_q == ST_BIT) |->
        (state_q == ST_BIT)[*8] ##1 (state_q == ST_BIT)[*8]
        ##1 (state_q != ST_BIT))
        else $error("bit time not 16 cycles");
    chk_no_drive_rst: assert property (
        @(posedge i_core_clk) !i_rst_n |=> !o_pin_oe)
        else $error("pin driven during reset");
    chk_oe_in_link: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        o_pin_oe |-> o_link_active)
        else $error("pin driven outside debug role");
    chk_link_after: assert property (
        @(posedge i_core_clk) $rose(i_rst_n) |=> o_link_active)
        else $error("link not active after reset");
    chk_mode_high: assert property (
        @(posedge i_core_clk)
        (!i_rst_n && i_qual_rst) ##1 (i_rst_n && i_pin_in)
        |=> !o_bkg_mode)
        else $error("high pin did not select normal");
    chk_mode_low: assert property (
        @(posedge i_core_clk)
        (!i_rst_n && i_qual_rst) ##1 (i_rst_n && !i_pin_in)
        |=> o_bkg_mode)
        else $error("low pin did not select background");
    chk_mode_hold: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        o_link_active |=> $stable(o_bkg_mode))
        else $error("mode changed outside reset");
    // A driven low must end in a driven high, never a bare release
    chk_speedup_hi: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        $fell(!o_pin_out && o_pin_oe) |-> (o_pin_oe && o_pin_out))
        else $error("release without speedup");
    // The speedup stays brief: one cycle, then the pin is let go
    chk_speedup_end: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (o_pin_oe && o_pin_out) |=> !o_pin_oe)
        else $error("speedup pulse too long");
    chk_pullup_on: assert property (
        @(posedge i_core_clk) o_pin_pullup_en)
        else $error("pullup off");
    chk_fast_cnt: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (state_q == ST_BIT && !bit_last)
        |=> bit_cnt_q == $past(bit_cnt_q) + 4'h1)
        else $error("counter skipped a clock");
    chk_rx_pulse: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        o_rx_bit.valid |=> !o_rx_bit.valid)
        else $error("receive valid longer than one cycle");

    // Main scenarios: both directions, both start modes, the speedup
    cov_tx_bit: cover property (@(posedge i_core_clk) tx_start);
    cov_rx_bit: cover property (@(posedge i_core_clk) o_rx_bit.valid);
    cov_bkg: cover property (@(posedge i_core_clk) o_bkg_mode);
    cov_normal: cover property (@(posedge i_core_clk)
        o_link_active && !o_bkg_mode);
    cov_speedup: cover property (@(posedge i_core_clk)
        o_pin_oe && o_pin_out);

endmodule // debug_pin_mode_select

//--- logic/dbg_pin_pkg.sv
package dbg_pin_pkg;

    // Cycles of the debug clock per bit time on the single-wire link
    localparam int unsigned BIT_CYCLES    = 16;
    localparam logic [3:0]  BIT_CNT_LAST  = 4'hf;
    // Last bit-time phase a zero is driven low; the speedup high comes one phase later
    localparam logic [3:0]  LOW_END_PHASE = 4'h3;
    localparam logic [3:0]  SPEEDUP_LEN   = 4'h1;
    // Sample point inside a received bit time
    localparam logic [3:0]  SAMPLE_PHASE  = 4'h9;
    // Mode flag value meaning active background mode
    localparam logic        MODE_BKG      = 1'h1;
    localparam logic        MODE_RST_VAL  = 1'h0;

    // Pin role selector
    typedef enum logic [2:0] {
        ST_MODESEL = 3'b001,
        ST_IDLE    = 3'b010,
        ST_BIT     = 3'b100
    } pin_state_t;

    // Three-signal form of the open-drain debug pin
    typedef struct packed {
        logic out;
        logic oe;
        logic pullup_en;
    } pin_drive_t;

    // One bit handed to the link by the debug controller
    typedef struct packed {
        logic valid;
        logic data;
    } tx_bit_t;

    // One bit received from the link
    typedef struct packed {
        logic valid;
        logic data;
    } rx_bit_t;

endpackage

//--- sim/debug_host_model.sv
`timescale 1ns/1ps
// Debug host pod on the far side of the shared pin
module debug_host_model (
    input  wire logic i_core_clk,  // Target debug clock
    input  wire logic i_hold_low,  // Ask for background mode in reset
    input  wire logic i_send,      // Start one host bit
    input  wire logic i_bit,       // Value of that bit
    output logic      o_drv_oe,    // Host drives the line
    output logic      o_drv_out    // Level the host drives
);
    logic [3:0] cnt_q;             // Phase within the bit time
    logic       busy_q = 1'b0;     // Bit in progress
    logic       bit_q;             // Bit being sent
    // Zero stays low past the sample point, one only briefly
    wire  [3:0] low_len = bit_q ? 4'h2 : 4'hd;
    // Bit timer on the target's own clock, 16 cycles a bit
    always @(posedge i_core_clk) begin
        if (i_send && !busy_q) begin
            busy_q <= 1'b1;
            bit_q  <= i_bit;
            cnt_q  <= 4'h0;
        end else if (busy_q) begin
            cnt_q  <= cnt_q + 4'h1;
            busy_q <= (cnt_q != 4'hf);
        end
    end
    // Low, then a one-cycle active high before letting go
    assign o_drv_oe  = i_hold_low | (busy_q & (cnt_q <= low_len));
    assign o_drv_out = ~i_hold_low & busy_q & (cnt_q == low_len);
endmodule // debug_host_model

//--- sim/debug_pin_mode_select_bench.sv
`timescale 1ns/1ps
// Drives resets and bits, checks mode and bit shapes
module debug_pin_mode_select_bench;
    import dbg_pin_pkg::*;
    logic i_core_clk = 1'b0, i_rst_n = 1'b0, i_qual_rst = 1'b1;
    logic hold = 1'b1, send = 1'b0, sbit = 1'b0, h_oe, h_out;
    logic o_pin_out, o_pin_oe, o_pull, o_tx_ready, o_bkg_mode, o_link;
    tx_bit_t i_tx_bit = '0;
    rx_bit_t o_rx_bit;
    int n_mismatch = 0, checks_done = 0, cyc = 0, low_n = 0;
    int exp_tx[$];                 // Expected low length of device bits
    logic exp_rx[$];               // Expected host bit values
    logic [31:0] seed = 32'h698b;
    // Pullup wins only when nobody drives the line
    wire pin = o_pin_oe ? o_pin_out : (h_oe ? h_out : o_pull);
    debug_pin_mode_select u_debug_pin_mode_select (.i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n), .i_qual_rst(i_qual_rst), .i_pin_in(pin),
        .i_tx_bit(i_tx_bit), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe),
        .o_pin_pullup_en(o_pull), .o_tx_ready(o_tx_ready),
        .o_rx_bit(o_rx_bit), .o_bkg_mode(o_bkg_mode), .o_link_active(o_link));
    debug_host_model u_debug_host_model (.i_core_clk(i_core_clk),
        .i_hold_low(hold), .i_send(send), .i_bit(sbit),
        .o_drv_oe(h_oe), .o_drv_out(h_out));
    // Clock at 40 MHz
    initial forever #12.5 i_core_clk = ~i_core_clk;
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction
    task automatic err(input string m);
        n_mismatch++;
        $display("ERROR %0t %s", $time, m);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Reset for 4 cycles, pin held low or free until one cycle after reset ends
    task automatic do_reset(input logic q, input logic h, input logic m);
        @(negedge i_core_clk);
        {i_rst_n, i_qual_rst, hold} = {1'b0, q, h};
        repeat (4) @(negedge i_core_clk);
        checks_done++;
        if (o_link !== 1'b0) err("link in reset");
        i_rst_n = 1'b1;
        @(negedge i_core_clk);
        {i_qual_rst, hold} = 2'b00;
        repeat (3) @(negedge i_core_clk);
        checks_done++;
        if (o_link !== 1'b1) err("link idle");
        checks_done++;
        if (o_bkg_mode !== m) err("mode");
    endtask
    // One device bit, zero low 4 cycles and one low 1 cycle
    task automatic tx(input logic b);
        for (int i = 0; i < 40 && o_tx_ready !== 1'b1; i++)
            @(negedge i_core_clk);
        exp_tx.push_back(b ? 1 : 4);
        i_tx_bit = '{valid: 1'b1, data: b};
        @(negedge i_core_clk);
        i_tx_bit = '0;
    endtask
    // One host bit once the target is idle, else the target's own
    // bit would hide the host's falling edge; then room to settle
    task automatic rx(input logic b);
        for (int i = 0; i < 40 && o_tx_ready !== 1'b1; i++)
            @(negedge i_core_clk);
        exp_rx.push_back(b);
        {send, sbit} = {1'b1, b};
        @(negedge i_core_clk);
        send = 1'b0;
        repeat (20) @(negedge i_core_clk);
    endtask
    // Cycle ceiling; a hang counts as a mismatch and ends the run
    always @(negedge i_core_clk) begin
        cyc++;
        if (cyc > 6000) begin
            err("timeout");
            conclude();
        end
    end
    // Watch settled outputs at the falling edge against the notes
    always @(negedge i_core_clk) begin
        if (o_pin_oe === 1'b1 && o_pin_out === 1'b0) low_n++;
        else if (low_n != 0) begin
            checks_done++;
            if (exp_tx.size() == 0 || low_n != exp_tx.pop_front()
                || o_pin_oe !== 1'b1) err("tx low or speedup");
            low_n = 0;
        end
        if (o_rx_bit.valid === 1'b1) begin
            checks_done++;
            if (exp_rx.size() == 0) err("rx bit unexpected");
            else if (o_rx_bit.data !== exp_rx.pop_front())
                err("rx bit");
        end
    end
    initial begin
        do_reset(1'b1, 1'b1, MODE_BKG);
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            tx(seed[0]);
            tx(seed[1]);
            rx(seed[2]);
        end
        do_reset(1'b0, 1'b1, MODE_BKG);
        do_reset(1'b1, 1'b0, ~MODE_BKG);
        do_reset(1'b0, 1'b1, ~MODE_BKG);
        tx(1'b0);
        rx(1'b1);
        checks_done++;
        if (exp_tx.size() + exp_rx.size() != 0) err("bits missing");
        conclude();
    end
endmodule // debug_pin_mode_select_bench
